// [shared/pm_clock_map.svh]
`ifndef PM_CLOCK_MAP_SVH
`define PM_CLOCK_MAP_SVH

// Oscillator control word layout.
`define PM_CTRL_W        8
`define PM_GATE_BIT      7
`define PM_PRI_FLAG_BIT  3
`define PM_SEL_HI        1
`define PM_SEL_LO        0
// Secondary-active flag position in the timer control word.
`define PM_SEC_FLAG_BIT  6

// Clock source select encodings.
`define PM_SEL_W         2
`define PM_SEL_DEF       2'h0
`define PM_SEL_SEC       2'h1
`define PM_SEL_PRI       2'h2
`define PM_SEL_INT       2'h3

// Reset values.
`define PM_GATE_RST      1'h0
`define PM_SEL_RST       2'h0

// Cycle counts, in cycles of the oscillator concerned.
`define PM_OST_W         11
`define PM_OST_CYCLES    11'h400
`define PM_OLD_CYCLES    11'h002
`define PM_NEW_CYCLES    11'h003

`endif

// [shared/pm_clock_pkg.sv]
`include "pm_clock_map.svh"

package pm_clock_pkg;

    // Gray coded along run, wait, old, new, run.
    typedef enum logic [2:0] {
        ST_RUN   = 3'h0,
        ST_WAIT  = 3'h1,
        ST_OLD   = 3'h3,
        ST_NEW   = 3'h2,
        ST_IDLE  = 3'h6,
        ST_SLEEP = 3'h4
    } pm_state_e;

    typedef logic [`PM_SEL_W-1:0] src_t;

    typedef struct packed {
        pm_state_e st;
        src_t      cur_src;
        src_t      tgt_src;
        logic      gate;
        src_t      sel;
        logic      pri_pwr;
        logic      pri_flag;
        logic      sec_flag;
        logic      cpu_en;
        logic      periph_en;
        logic      booted;
        logic      skip_old;
    } pm_ctl_s;

endpackage : pm_clock_pkg

// [shared/cnt_if.sv]
`timescale 1ns/1ps
`default_nettype none

// Request and answer between the controller and one oscillator cycle counter.
interface cnt_if;
    logic run;
    logic tick;
    logic done;

    modport counter (input run, input tick, output done);
    modport user    (output run, output tick, input done);
endinterface : cnt_if

`default_nettype wire

// [hdl/osc_tick_counter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pm_clock_map.svh"

// Counts ticks of one oscillator while run is high; done holds once LIMIT is reached.
module osc_tick_counter #(
    parameter int                 WIDTH = `PM_OST_W,
    parameter logic [WIDTH-1:0]   LIMIT = `PM_OST_CYCLES
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset_n,
    // Controller side.
    cnt_if.counter   cnt
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             done;
    } cnt_s;

    cnt_s r_q;
    cnt_s r_d;

    // Dropping run clears the count, so every use starts from zero.
    always_comb begin
        r_d = r_q;
        if (!cnt.run) begin
            r_d = '0;
        end else if (cnt.tick && !r_q.done) begin
            r_d.count = r_q.count + 1'b1;
            r_d.done  = (r_q.count == LIMIT - 1'b1);
        end
    end

    // State register.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign cnt.done = r_q.done;
endmodule : osc_tick_counter

`default_nettype wire

// [hdl/power_mode_clock_switch.sv]
// Function
// R1: Bit 7 of control word gates CPU clocking; bits 1:0 select the source.
// R2: Select 10 is primary, 01 secondary timer oscillator, 11 internal oscillator.
// R3: Sleep instruction with gate bit 0 stops all CPU and peripheral clocks.
// R4: Sleep instruction with gate bit 1 stops CPU, peripherals keep selected source.
// R5: Changing the select field starts a switch once the new source runs.
// R6: Sleep instruction only triggers; gate bit at execution alone picks mode.
// R7: A switch takes two old-source cycles plus three to four new-source cycles.
// R8: Primary flag at bit 3, secondary flag at timer bit 6; neither means internal.
// R9: Every later sleep instruction uses the gate bit at its own execution.
// R10: Reset lands in primary run with primary flag set, unless two-speed start.
// R11: Secondary run switches to timer oscillator, stops primary, swaps flags.
// R12: Select 01 with timer oscillator disabled does not enter secondary run.
// R13: Timer oscillator enabled but not oscillating holds device clocks off.
// R14: Secondary to primary keeps timer clocking until primary ready, then swaps flags.
// R15: Return to primary leaves gate bit and select unchanged, timer keeps running.
// R16: Every run mode clocks CPU and peripherals; only the source differs.
// R17: Primary is ready only after the start-up counter counts 1024 of its cycles.
// R18: Switching to internal oscillator stops primary and clears the primary flag.
// R19: Switching is glitch free; flags change only once the new source drives.
`timescale 1ns/1ps
`default_nettype none
`include "pm_clock_map.svh"

module power_mode_clock_switch
    import pm_clock_pkg::*;
(
    // Clock and reset.
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    // Control word write from the CPU core.
    input  wire logic                 ctrl_wr,
    input  wire logic [`PM_CTRL_W-1:0] ctrl_wdata,
    // Sleep instruction strobe and wake event.
    input  wire logic                 sleep_exec,
    input  wire logic                 wake_event,
    // Configuration and oscillator status.
    input  wire logic                 secondary_osc_enable,
    input  wire logic                 sec_osc_running,
    input  wire logic                 two_speed_en,
    // One-cycle pulses marking a cycle of each oscillator.
    input  wire logic                 pri_osc_tick,
    input  wire logic                 sec_osc_tick,
    input  wire logic                 int_osc_tick,
    // Control word fields and status flags.
    output logic                      cpu_gate_select,
    output logic [`PM_SEL_W-1:0]      clock_source_select,
    output logic                      primary_clock_active_flag,
    output logic                      secondary_clock_active_flag,
    // Clock gates and oscillator control.
    output logic                      cpu_clk_en,
    output logic                      periph_clk_en,
    output logic [`PM_SEL_W-1:0]      active_source,
    output logic                      pri_osc_power,
    output pm_state_e                 power_state
);
    pm_ctl_s r_q;
    pm_ctl_s r_d;

    cnt_if ost_if ();
    cnt_if old_if ();
    cnt_if new_if ();

    // Primary start-up counter runs only while the primary oscillator is powered.
    osc_tick_counter #(.WIDTH(`PM_OST_W), .LIMIT(`PM_OST_CYCLES)) u_ost ( // R17
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .cnt     (ost_if.counter)
    );

    // Old source cycles before it is released.
    osc_tick_counter #(.WIDTH(`PM_OST_W), .LIMIT(`PM_OLD_CYCLES)) u_old (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .cnt     (old_if.counter)
    );

    // New source cycles before it is connected.
    osc_tick_counter #(.WIDTH(`PM_OST_W), .LIMIT(`PM_NEW_CYCLES)) u_new (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .cnt     (new_if.counter)
    );

    // Tick of a given source, used for both sides of a switch.
    function automatic logic src_tick(input src_t s, input logic p, input logic t,
                                      input logic i);
        logic r;
        r = i;
        case (s)
            `PM_SEL_PRI: r = p;
            `PM_SEL_SEC: r = t;
            default:     r = i;
        endcase
        return r;
    endfunction

    // The select field decoded to a source; 00 follows the primary.
    src_t sel_src;
    logic sel_allowed;
    logic src_ready;
    logic target_ready;

    always_comb begin
        case (r_q.sel) // R2
            `PM_SEL_SEC: sel_src = `PM_SEL_SEC;
            `PM_SEL_INT: sel_src = `PM_SEL_INT;
            default:     sel_src = `PM_SEL_PRI;
        endcase
        sel_allowed = (sel_src != `PM_SEL_SEC) || secondary_osc_enable; // R12
        case (r_q.tgt_src)
            `PM_SEL_PRI: src_ready = ost_if.done; // R17
            `PM_SEL_SEC: src_ready = sec_osc_running; // R13
            default:     src_ready = 1'b1;
        endcase
        target_ready = src_ready;
    end

    // Counters are cleared whenever they are not in use.
    assign ost_if.run  = r_q.pri_pwr;
    assign ost_if.tick = pri_osc_tick;
    assign old_if.run  = (r_q.st == ST_OLD);
    assign old_if.tick = src_tick(r_q.cur_src, pri_osc_tick, sec_osc_tick, int_osc_tick);
    assign new_if.run  = (r_q.st == ST_NEW);
    assign new_if.tick = src_tick(r_q.tgt_src, pri_osc_tick, sec_osc_tick, int_osc_tick);

    // Next-state logic. Register writes are taken in every state so that software
    // never loses a write; sleep entry is only started from run, a switch from run or on wake from sleep.
    always_comb begin
        r_d = r_q;
        if (ctrl_wr) begin // R15
            r_d.gate = ctrl_wdata[`PM_GATE_BIT]; // R1
            r_d.sel  = ctrl_wdata[`PM_SEL_HI:`PM_SEL_LO]; // R1
        end
        case (r_q.st)
            ST_RUN: begin
                r_d.cpu_en    = 1'b1; // R16
                r_d.periph_en = 1'b1; // R16
                if (!r_q.booted) begin
                    // Strap is caught on the first edge after release.
                    r_d.booted = 1'b1;
                    if (two_speed_en) begin
                        r_d.cur_src  = `PM_SEL_INT;
                        r_d.pri_flag = 1'b0;
                        r_d.tgt_src  = `PM_SEL_PRI;
                        r_d.skip_old = 1'b0;
                        r_d.st       = ST_WAIT;
                    end
                end else if (sleep_exec) begin
                    // Gate bit as it stands at execution decides the mode.
                    if (r_q.gate) begin // R4 R6 R9
                        r_d.cpu_en = 1'b0;
                        r_d.st     = ST_IDLE;
                    end else begin // R3 R6 R9
                        r_d.cpu_en    = 1'b0;
                        r_d.periph_en = 1'b0;
                        r_d.pri_pwr   = 1'b0;
                        r_d.pri_flag  = 1'b0;
                        r_d.sec_flag  = 1'b0;
                        r_d.st        = ST_SLEEP;
                    end
                end else if (sel_src != r_q.cur_src && sel_allowed) begin // R5 R12
                    r_d.tgt_src  = sel_src;
                    r_d.skip_old = 1'b0;
                    r_d.st       = ST_WAIT;
                    if (sel_src == `PM_SEL_PRI) begin
                        r_d.pri_pwr = 1'b1; // R14
                    end
                    // A timer that is not yet oscillating gates the clocks from the
                    // first wait cycle, so no edge of a dead source ever gets through.
                    if (sel_src == `PM_SEL_SEC && !sec_osc_running) begin // R13
                        r_d.cpu_en    = 1'b0;
                        r_d.periph_en = 1'b0;
                    end
                end
            end
            ST_WAIT: begin
                // Old source keeps clocking while the primary warms up; a dead
                // timer oscillator holds the clocks off instead.
                if (r_q.tgt_src == `PM_SEL_SEC && !sec_osc_running) begin // R13
                    r_d.cpu_en    = 1'b0;
                    r_d.periph_en = 1'b0;
                end
                if (target_ready) begin // R14 R17
                    r_d.st = r_q.skip_old ? ST_NEW : ST_OLD;
                end
            end
            ST_OLD: begin
                if (old_if.done) begin // R7
                    r_d.cpu_en    = 1'b0; // R19
                    r_d.periph_en = 1'b0; // R19
                    r_d.st        = ST_NEW;
                end
            end
            ST_NEW: begin
                r_d.cpu_en    = 1'b0;
                r_d.periph_en = 1'b0;
                if (new_if.done) begin // R7 R19
                    r_d.cur_src   = r_q.tgt_src;
                    r_d.pri_flag  = (r_q.tgt_src == `PM_SEL_PRI); // R8 R11 R14 R18
                    r_d.sec_flag  = (r_q.tgt_src == `PM_SEL_SEC); // R8 R11 R14
                    r_d.pri_pwr   = (r_q.tgt_src == `PM_SEL_PRI); // R11 R18
                    r_d.cpu_en    = 1'b1;
                    r_d.periph_en = 1'b1;
                    r_d.st        = ST_RUN;
                end
            end
            ST_IDLE: begin
                r_d.cpu_en    = 1'b0;
                r_d.periph_en = 1'b1; // R4
                if (wake_event) begin
                    r_d.cpu_en = 1'b1;
                    r_d.st     = ST_RUN;
                end
            end
            ST_SLEEP: begin
                r_d.cpu_en    = 1'b0;
                r_d.periph_en = 1'b0;
                if (wake_event) begin
                    // No old clock runs in sleep, so only the new side is counted.
                    r_d.tgt_src  = sel_allowed ? sel_src : r_q.cur_src;
                    r_d.pri_pwr  = ((sel_allowed ? sel_src : r_q.cur_src) == `PM_SEL_PRI);
                    r_d.skip_old = 1'b1;
                    r_d.st       = ST_WAIT;
                end
            end
            default: begin
                r_d.st = ST_RUN;
            end
        endcase
    end

    // State register; reset lands in primary run with the primary flag set.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin // R10
            r_q           <= '0;
            r_q.st        <= ST_RUN;
            r_q.cur_src   <= `PM_SEL_PRI;
            r_q.tgt_src   <= `PM_SEL_PRI;
            r_q.gate      <= `PM_GATE_RST;
            r_q.sel       <= `PM_SEL_RST;
            r_q.pri_pwr   <= 1'b1;
            r_q.pri_flag  <= 1'b1;
            r_q.cpu_en    <= 1'b1;
            r_q.periph_en <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs come straight from the state register.
    assign cpu_gate_select             = r_q.gate;
    assign clock_source_select         = r_q.sel;
    assign primary_clock_active_flag   = r_q.pri_flag;
    assign secondary_clock_active_flag = r_q.sec_flag;
    assign cpu_clk_en                  = r_q.cpu_en;
    assign periph_clk_en               = r_q.periph_en;
    assign active_source               = r_q.cur_src;
    assign pri_osc_power               = r_q.pri_pwr;
    assign power_state                 = r_q.st;

    property p_sleep_stop;
        @(posedge clk_sys) disable iff (!reset_n)
        (r_q.st == ST_RUN && r_q.booted && sleep_exec && !r_q.gate)
            |=> (r_q.st == ST_SLEEP && !cpu_clk_en && !periph_clk_en && !pri_osc_power);
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("sleep did not stop clocks"); // R3

    property p_idle_entry;
        @(posedge clk_sys) disable iff (!reset_n)
        (r_q.st == ST_RUN && r_q.booted && sleep_exec && r_q.gate)
            |=> (r_q.st == ST_IDLE && !cpu_clk_en && periph_clk_en && $stable(active_source));
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong"); // R4

    property p_run_clocked;
        @(posedge clk_sys) disable iff (!reset_n)
        (r_q.st == ST_RUN) |-> (cpu_clk_en && periph_clk_en);
    endproperty
    a_run_clocked: assert property (p_run_clocked) else $error("run mode not clocked"); // R16

    property p_flags_exclusive;
        @(posedge clk_sys) disable iff (!reset_n)
        !(primary_clock_active_flag && secondary_clock_active_flag)
            && (primary_clock_active_flag -> active_source == `PM_SEL_PRI);
    endproperty
    a_flags_exclusive: assert property (p_flags_exclusive) else $error("flags conflict"); // R8

    property p_sec_blocked;
        @(posedge clk_sys) disable iff (!reset_n)
        (r_q.st == ST_RUN && r_q.booted && !sleep_exec && r_q.sel == `PM_SEL_SEC
            && !secondary_osc_enable) |=> (r_q.st == ST_RUN);
    endproperty
    a_sec_blocked: assert property (p_sec_blocked) else $error("secondary entered disabled"); // R12

    property p_pri_needs_ost;
        @(posedge clk_sys) disable iff (!reset_n)
        $rose(primary_clock_active_flag) |-> $past(ost_if.done);
    endproperty
    a_pri_needs_ost: assert property (p_pri_needs_ost) else $error("primary before start-up"); // R17

    property p_pri_off;
        @(posedge clk_sys) disable iff (!reset_n)
        (r_q.st == ST_RUN && active_source != `PM_SEL_PRI) |-> !pri_osc_power;
    endproperty
    a_pri_off: assert property (p_pri_off) else $error("primary left powered"); // R18

    property p_old_counted;
        @(posedge clk_sys) disable iff (!reset_n)
        (r_q.st == ST_OLD ##1 r_q.st == ST_NEW) |-> $past(old_if.done);
    endproperty
    a_old_counted: assert property (p_old_counted) else $error("old cycles skipped"); // R7

    property p_switch_start;
        @(posedge clk_sys) disable iff (!reset_n)
        (r_q.st == ST_RUN && r_q.booted && !sleep_exec && sel_src != r_q.cur_src
            && sel_allowed) |=> (r_q.st == ST_WAIT);
    endproperty
    a_switch_start: assert property (p_switch_start) else $error("switch not started"); // R5

    property p_sel_kept;
        @(posedge clk_sys) disable iff (!reset_n)
        !ctrl_wr |=> ($stable(clock_source_select) && $stable(cpu_gate_select));
    endproperty
    a_sel_kept: assert property (p_sel_kept) else $error("control bits changed"); // R15
endmodule : power_mode_clock_switch

`default_nettype wire

// [dv/osc_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Stand-ins for the three oscillators; each tick marks one cycle of that source.
module osc_model (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // Timer oscillator enable, as the core sets it.
    input  wire logic secondary_osc_enable,
    // Oscillator cycle marks and timer status.
    output logic      pri_osc_tick,
    output logic      sec_osc_tick,
    output logic      int_osc_tick,
    output logic      sec_osc_running
);
    int unsigned phase;
    int unsigned warm;

    // Ticks move on the falling edge so the design samples settled pulses.
    // The timer needs a warm-up before it oscillates, which exercises the hold-off path.
    always @(negedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase = 0;
            warm = 0;
            pri_osc_tick <= 1'b0;
            sec_osc_tick <= 1'b0;
            int_osc_tick <= 1'b0;
            sec_osc_running <= 1'b0;
        end else begin
            phase = phase + 1;
            if (!secondary_osc_enable) begin
                warm = 0;
            end else if (warm < 40) begin
                warm = warm + 1;
            end
            sec_osc_running <= (warm >= 40);
            pri_osc_tick <= (phase % 2 == 0);
            int_osc_tick <= (phase % 3 == 0);
            sec_osc_tick <= (warm >= 40) && (phase % 5 == 0);
        end
    end
endmodule // osc_model

`default_nettype wire

// [dv/power_mode_clock_switch_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pm_clock_map.svh"

module power_mode_clock_switch_tb
    import pm_clock_pkg::*;
;
    logic clk_sys, reset_n, ctrl_wr, sleep_exec, wake_event, two_speed_en;
    logic [`PM_CTRL_W-1:0] ctrl_wdata;
    logic secondary_osc_enable, sec_osc_running, pri_osc_tick, sec_osc_tick, int_osc_tick;
    logic cpu_gate_select, primary_clock_active_flag, secondary_clock_active_flag;
    logic cpu_clk_en, periph_clk_en, pri_osc_power;
    logic [`PM_SEL_W-1:0] clock_source_select, active_source, tgt, src_before;
    pm_state_e power_state;
    int errors, n_compared, cycles, old_ticks, new_ticks, wait_pri, hold_seen, hold_bad;

    power_mode_clock_switch power_mode_clock_switch_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .sleep_exec(sleep_exec),
        .wake_event(wake_event), .secondary_osc_enable(secondary_osc_enable),
        .sec_osc_running(sec_osc_running), .two_speed_en(two_speed_en),
        .pri_osc_tick(pri_osc_tick), .sec_osc_tick(sec_osc_tick), .int_osc_tick(int_osc_tick),
        .cpu_gate_select(cpu_gate_select), .clock_source_select(clock_source_select),
        .primary_clock_active_flag(primary_clock_active_flag),
        .secondary_clock_active_flag(secondary_clock_active_flag), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .active_source(active_source),
        .pri_osc_power(pri_osc_power), .power_state(power_state));

    osc_model osc_model_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .secondary_osc_enable(secondary_osc_enable), .pri_osc_tick(pri_osc_tick),
        .sec_osc_tick(sec_osc_tick), .int_osc_tick(int_osc_tick),
        .sec_osc_running(sec_osc_running));

    // A 40 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Tick of a given source, used to count old and new source cycles.
    function automatic logic tick_of(input logic [1:0] s);
        return (s == `PM_SEL_SEC) ? sec_osc_tick : (s == `PM_SEL_INT) ? int_osc_tick : pri_osc_tick;
    endfunction

    // Watches every switch; counters are cleared by the bench before each one.
    always @(posedge clk_sys) begin
        cycles++;
        if (power_state === ST_OLD && tick_of(active_source)) old_ticks++;
        if (power_state === ST_NEW && tick_of(tgt)) new_ticks++;
        if (power_state === ST_WAIT && pri_osc_tick) wait_pri++;
        if (power_state === ST_WAIT && (active_source !== src_before)) hold_bad++;
        if (power_state === ST_WAIT && tgt == `PM_SEL_SEC && !sec_osc_running) begin
            hold_seen++;
            if (cpu_clk_en !== 1'b0 || periph_clk_en !== 1'b0) hold_bad++;
        end
        if (cycles == 90000) begin
            errors++;
            close_out();
        end
    end

    task automatic check(input logic [2:0] seen, input logic [2:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("Counts: %0d compared, %0d mismatched", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One control word write, then enough edges for a switch to have started.
    task automatic wr(input logic g, input logic [1:0] s);
        @(negedge clk_sys);
        ctrl_wr = 1'b1;
        ctrl_wdata = 8'h00;
        ctrl_wdata[`PM_GATE_BIT] = g;
        ctrl_wdata[`PM_SEL_HI:`PM_SEL_LO] = s;
        @(negedge clk_sys);
        ctrl_wr = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask

    // Bounded wait for the run state, then check source, flags and gates.
    task automatic settle(input logic g, input logic [1:0] s, input logic [1:0] e, input logic t);
        int n;
        n = 0;
        while (power_state !== ST_RUN && n < 6000) begin
            @(negedge clk_sys);
            n++;
        end
        check(3'(active_source), 3'(e));
        check(3'(primary_clock_active_flag), 3'(e == `PM_SEL_PRI));
        check(3'(secondary_clock_active_flag), 3'(e == `PM_SEL_SEC));
        check(3'(pri_osc_power), 3'(e == `PM_SEL_PRI));
        check(3'({cpu_clk_en, periph_clk_en}), 3'h3);
        check(3'({cpu_gate_select, clock_source_select}), 3'({g, s}));
        check(3'(hold_bad != 0), 3'h0);
        if (t) begin
            check(3'(old_ticks), 3'h2);
            check(3'(new_ticks), 3'h3);
            if (e == `PM_SEL_PRI) check(3'(wait_pri >= 1020), 3'h1);
        end
    endtask

    task automatic prep(input logic [1:0] e);
        src_before = active_source;
        tgt = e;
        old_ticks = 0;
        new_ticks = 0;
        wait_pri = 0;
        hold_bad = 0;
    endtask

    task automatic sw(input logic g, input logic [1:0] s, input logic [1:0] e);
        logic t;
        t = (e != active_source);
        prep(e);
        wr(g, s);
        settle(g, s, e, t);
        $display("Switch to select %0d done", s);
    endtask

    // Sleep instruction with gate bit g, then wake and return to the same source.
    task automatic slp(input logic g);
        logic [1:0] s;
        logic [1:0] e;
        logic [1:0] fl;
        s = clock_source_select;
        e = active_source;
        wr(g, s);
        fl = {primary_clock_active_flag, secondary_clock_active_flag};
        sleep_exec = 1'b1;
        @(negedge clk_sys);
        sleep_exec = 1'b0;
        check(3'(power_state), g ? 3'(ST_IDLE) : 3'(ST_SLEEP));
        check(3'({cpu_clk_en, periph_clk_en}), 3'({1'b0, g}));
        check(3'({primary_clock_active_flag, secondary_clock_active_flag}), g ? 3'(fl) : 3'h0);
        repeat (5) @(negedge clk_sys);
        prep(e);
        wake_event = 1'b1;
        @(negedge clk_sys);
        wake_event = 1'b0;
        settle(g, s, e, 1'b0);
        $display("Sleep with gate %0d done", g);
    endtask

    initial begin
        logic [1:0] s;
        reset_n = 1'b0;
        {ctrl_wr, sleep_exec, wake_event, two_speed_en, secondary_osc_enable} = 5'h00;
        ctrl_wdata = 8'h00;
        tgt = `PM_SEL_PRI;
        src_before = `PM_SEL_PRI;
        void'($urandom(99977));
        repeat (20) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        // Power-up lands in primary run with the primary flag set.
        check(3'(power_state), 3'(ST_RUN));
        check(3'({primary_clock_active_flag, secondary_clock_active_flag}), 3'h2);
        check(3'(active_source), 3'(`PM_SEL_PRI));
        check(3'({cpu_gate_select, clock_source_select}), 3'h0);
        $display("Reset test done");
        // Timer select with the timer disabled is stored but never taken.
        prep(`PM_SEL_PRI);
        wr(1'b0, `PM_SEL_SEC);
        repeat (20) @(negedge clk_sys);
        check(3'(power_state), 3'(ST_RUN));
        check(3'(active_source), 3'(`PM_SEL_PRI));
        check(3'(clock_source_select), 3'(`PM_SEL_SEC));
        // Enabling the timer starts the pending switch; clocks hold off while it warms.
        prep(`PM_SEL_SEC);
        hold_seen = 0;
        secondary_osc_enable = 1'b1;
        repeat (2) @(negedge clk_sys);
        settle(1'b0, `PM_SEL_SEC, `PM_SEL_SEC, 1'b0);
        check(3'(hold_seen > 0), 3'h1);
        $display("Timer enable test done");
        sw(1'b0, `PM_SEL_PRI, `PM_SEL_PRI);
        sw(1'b0, `PM_SEL_INT, `PM_SEL_INT);
        sw(1'b0, `PM_SEL_DEF, `PM_SEL_PRI);
        sw(1'b1, `PM_SEL_SEC, `PM_SEL_SEC);
        // Random sources and gate settings, with back-to-back sleeps of opposite gate.
        for (int i = 0; i < 6; i++) begin
            s = 2'(1 + $urandom % 3);
            sw(1'($urandom), s, s);
            s[0] = 1'($urandom);
            slp(s[0]);
            slp(~s[0]);
        end
        // Mid-run reset with two-speed start: internal first, then primary after start-up.
        @(negedge clk_sys);
        reset_n = 1'b0;
        two_speed_en = 1'b1;
        repeat (4) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        check(3'(power_state), 3'(ST_WAIT));
        check(3'(active_source), 3'(`PM_SEL_INT));
        check(3'({primary_clock_active_flag, secondary_clock_active_flag}), 3'h0);
        prep(`PM_SEL_PRI);
        settle(1'b0, `PM_SEL_DEF, `PM_SEL_PRI, 1'b1);
        $display("Two-speed start test done");
        close_out();
    end
endmodule // power_mode_clock_switch_tb

`default_nettype wire
